// ---- remappable_pin_select_matrix.sv ----
`timescale 1ns/1ps
module remappable_pin_select_matrix
	import pin_select_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [REG_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [REG_W-1:0] reg_rdata_o,
	input wire logic serial1_transmit_i,
	input wire logic serial2_transmit_i,
	input wire logic serial3_transmit_i,
	input wire logic serial4_transmit_i,
	input wire logic serial3_request_to_send_i,
	input wire logic serial4_request_to_send_i,
	input wire logic sync_port2_data_out_i,
	input wire logic sync_port2_clock_out_i,
	input wire logic sync_port2_select_out_i,
	input wire logic sync_port3_data_out_i,
	input wire logic sync_port3_clock_out_i,
	input wire logic sync_port3_select_out_i,
	input wire logic codec_data_out_i,
	input wire logic codec_clock_out_i,
	input wire logic codec_frame_sync_i,
	input wire logic can_unit1_transmit_i,
	input wire logic can_unit2_transmit_i,
	input wire logic [7:0] compare_channel_out_i,
	input wire logic [4:0] comparator_out_i,
	input wire logic primary_timebase_sync_out_i,
	input wire logic secondary_timebase_sync_out_i,
	input wire logic encoder1_counter_compare_out_i,
	input wire logic encoder2_counter_compare_out_i,
	input wire logic reference_clock_out_i,
	input wire logic port126_data_i,
	input wire logic port127_data_i,
	input wire logic comparator1_source_i,
	input wire logic [PIN_IN_N-1:0] remappable_input_pin_i,
	output logic pin126_o,
	output logic pin127_o,
	output logic pin126_remapped_o,
	output logic pin127_remapped_o,
	output logic deadtime_comp6_o
);

	////////////////////////////////////////////////////////////////////////
	// select registers
	logic [SRC_W-1:0] deadtime_comp6_source;
	logic [CODE_W-1:0] pin126_output_code;
	logic [CODE_W-1:0] pin127_output_code;
	logic [PIN_IN_N-1:0] pin_meta;
	logic [PIN_IN_N-1:0] pin_sync;

	wire hit_src = (reg_addr_i == ADDR_DTCOMP6_SEL);
	wire hit_pin = (reg_addr_i == ADDR_PIN126_127_SEL) && LARGE_VARIANT;
	wire wr_src = reg_wr_i && hit_src;
	wire wr_pin = reg_wr_i && hit_pin;

	// only the implemented field bits are stored; the rest never exist
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			deadtime_comp6_source <= RST_SRC;
			pin126_output_code <= RST_CODE;
			pin127_output_code <= RST_CODE;
		end
		else
		begin
			if (wr_src)
				deadtime_comp6_source <= reg_wdata_i[DTCOMP6_LSB +: SRC_W];
			if (wr_pin)
			begin
				pin126_output_code <= reg_wdata_i[PIN126_LSB +: CODE_W];
				pin127_output_code <= reg_wdata_i[PIN127_LSB +: CODE_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: data valid only in the cycle after the strobe
	logic [REG_W-1:0] src_word;
	logic [REG_W-1:0] pin_word;
	logic [REG_W-1:0] rd_word;

	assign src_word = REG_W'(deadtime_comp6_source) << DTCOMP6_LSB;
	assign pin_word = (REG_W'(pin126_output_code) << PIN126_LSB)
		| (REG_W'(pin127_output_code) << PIN127_LSB);
	assign rd_word = hit_src ? src_word : (hit_pin ? pin_word : RST_SELECT);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= RST_SELECT;
		else
			reg_rdata_o <= reg_rd_i ? rd_word : RST_SELECT;
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral bundle and the two pin multiplexers
	logic [PERIPH_N-1:0] periph;

	assign periph = {
		comparator_out_i[4:3],
		reference_clock_out_i,
		encoder2_counter_compare_out_i,
		encoder1_counter_compare_out_i,
		secondary_timebase_sync_out_i,
		primary_timebase_sync_out_i,
		sync_port3_select_out_i,
		sync_port3_clock_out_i,
		sync_port3_data_out_i,
		serial4_request_to_send_i,
		serial4_transmit_i,
		serial3_request_to_send_i,
		serial3_transmit_i,
		comparator_out_i[2:0],
		compare_channel_out_i,
		can_unit2_transmit_i,
		can_unit1_transmit_i,
		codec_frame_sync_i,
		codec_clock_out_i,
		codec_data_out_i,
		sync_port2_select_out_i,
		sync_port2_clock_out_i,
		sync_port2_data_out_i,
		serial2_transmit_i,
		serial1_transmit_i,
		1'b0
	};

	pin_route_if rt126 ();
	pin_route_if rt127 ();

	assign rt126.code = pin126_output_code;
	assign rt126.periph = periph;
	assign rt127.code = pin127_output_code;
	assign rt127.periph = periph;

	pin_output_mux u_mux126 (.rt(rt126.mux));
	pin_output_mux u_mux127 (.rt(rt127.mux));

	// pins fall back to the port latch whenever no peripheral is selected
	wire next_pin126 = rt126.routed ? rt126.level : port126_data_i;
	wire next_pin127 = rt127.routed ? rt127.level : port127_data_i;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin126_o <= 1'b0;
			pin127_o <= 1'b0;
			pin126_remapped_o <= 1'b0;
			pin127_remapped_o <= 1'b0;
		end
		else
		begin
			pin126_o <= next_pin126;
			pin127_o <= next_pin127;
			pin126_remapped_o <= rt126.routed;
			pin127_remapped_o <= rt127.routed;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dead-time compensation input 6
	// pin inputs are asynchronous, so two stages before the selector
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= remappable_input_pin_i;
			pin_sync <= pin_meta;
		end
	end

	wire src_is_ground = (deadtime_comp6_source == SRC_GROUND);
	wire src_is_comp1 = (deadtime_comp6_source == SRC_COMP1);
	wire src_is_pin = (deadtime_comp6_source > SRC_COMP1) && (deadtime_comp6_source <= SRC_PIN_MAX);
	// codes above the last pin have no source and read as ground
	wire next_comp6 = src_is_comp1 ? comparator1_source_i
		: (src_is_pin ? pin_sync[deadtime_comp6_source] : 1'b0);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			deadtime_comp6_o <= 1'b0;
		else
			deadtime_comp6_o <= next_comp6;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	wire [2:0] cmp126_idx = pin126_output_code[2:0];

	a_default_port_pin: assert property (
		pin126_output_code == CODE_DEFAULT_PORT |=> pin126_o == $past(port126_data_i) && !pin126_remapped_o)
		else $error("pin126 not on port logic for code zero");
	a_serial_tx_route: assert property (
		pin126_output_code == CODE_SER3_TX |=> pin126_o == $past(serial3_transmit_i) && pin126_remapped_o)
		else $error("serial3 transmit not routed");
	a_sync_port_route: assert property (
		pin127_output_code == CODE_SYNC3_CLK |=> pin127_o == $past(sync_port3_clock_out_i))
		else $error("sync port3 clock not routed");
	a_codec_fs_route: assert property (
		pin126_output_code == CODE_CODEC_FS |=> pin126_o == $past(codec_frame_sync_i))
		else $error("codec frame sync not routed");
	a_can_tx_route: assert property (
		pin127_output_code == CODE_CAN2_TX |=> pin127_o == $past(can_unit2_transmit_i))
		else $error("can2 transmit not routed");
	a_compare_route: assert property (
		pin126_output_code >= CODE_COMPARE_FIRST && pin126_output_code <= CODE_COMPARE_LAST
		|=> pin126_o == $past(compare_channel_out_i[cmp126_idx]))
		else $error("compare channel order wrong");
	a_comparator_route: assert property (
		pin127_output_code == CODE_COMP4 |=> pin127_o == $past(comparator_out_i[3]))
		else $error("comparator4 not routed");
	a_rts_route: assert property (
		pin126_output_code == CODE_SER4_RTS |=> pin126_o == $past(serial4_request_to_send_i))
		else $error("serial4 rts not routed");
	a_timebase_route: assert property (
		pin127_output_code == CODE_TB2_SYNC |=> pin127_o == $past(secondary_timebase_sync_out_i))
		else $error("secondary sync not routed");
	a_encoder_route: assert property (
		pin126_output_code == CODE_ENC2_CMP |=> pin126_o == $past(encoder2_counter_compare_out_i))
		else $error("encoder2 compare not routed");
	a_refclk_route: assert property (
		pin127_output_code == CODE_REF_CLK |=> pin127_o == $past(reference_clock_out_i))
		else $error("reference clock not routed");
	a_comp6_ground: assert property (
		src_is_ground ##1 src_is_ground |-> !deadtime_comp6_o)
		else $error("dead-time input 6 not grounded");
	a_comp6_pin124: assert property (
		deadtime_comp6_source == SRC_PIN_MAX |=> deadtime_comp6_o == $past(pin_sync[124]))
		else $error("dead-time input 6 not on pin 124");
	a_small_variant_regs: assert property (
		!LARGE_VARIANT && reg_rd_i && reg_addr_i == ADDR_PIN126_127_SEL |=> reg_rdata_o == RST_SELECT)
		else $error("pin126/127 register present on small variant");
	a_unused_bits_zero: assert property (
		reg_rd_i && hit_pin |=> reg_rdata_o[15:14] == 2'h0 && reg_rdata_o[7:6] == 2'h0)
		else $error("unimplemented bits read nonzero");
	// the source field owns bit 6, so its register gets its own check
	a_src_bits_zero: assert property (
		reg_rd_i && hit_src |=> reg_rdata_o[REG_W-1:SRC_W] == '0)
		else $error("bits above source field read nonzero");
	a_unmapped_read: assert property (
		reg_rd_i && !hit_src && !hit_pin |=> reg_rdata_o == RST_SELECT)
		else $error("unmapped register read nonzero");
	a_write_readback: assert property (
		wr_src ##1 reg_rd_i && hit_src && !reg_wr_i |=> reg_rdata_o == REG_W'($past(reg_wdata_i[6:0], 2)))
		else $error("source field write not read back");
	a_unassigned_code: assert property (
		pin126_output_code > CODE_SYNC3_SEL && pin126_output_code < CODE_TB1_SYNC
		|=> !pin126_remapped_o && pin126_o == $past(port126_data_i))
		else $error("unassigned code drove the pin");
	a_pin127_default: assert property (
		pin127_output_code == CODE_DEFAULT_PORT |=> pin127_o == $past(port127_data_i) && !pin127_remapped_o)
		else $error("pin127 not on port logic for code zero");
	a_serial1_route: assert property (
		pin127_output_code == CODE_SER1_TX |=> pin127_o == $past(serial1_transmit_i) && pin127_remapped_o)
		else $error("serial1 transmit not routed");
	a_sync2_route: assert property (
		pin126_output_code == CODE_SYNC2_DATA |=> pin126_o == $past(sync_port2_data_out_i))
		else $error("sync port2 data not routed");
	a_comp6_comparator: assert property (
		src_is_comp1 |=> deadtime_comp6_o == $past(comparator1_source_i))
		else $error("dead-time input 6 not on comparator 1");
	a_comp6_above_pins: assert property (
		deadtime_comp6_source > SRC_PIN_MAX |=> !deadtime_comp6_o)
		else $error("dead-time input 6 not grounded above last pin");
	a_small_variant_pins: assert property (
		!LARGE_VARIANT |-> !pin126_remapped_o && !pin127_remapped_o)
		else $error("pin remapped on small variant");

	c_pin_remapped: cover property (wr_pin ##1 pin126_remapped_o [*2]);
	c_comp6_from_pin: cover property (src_is_pin ##1 deadtime_comp6_o);
	c_read_after_write: cover property (wr_src ##1 reg_rd_i);
	c_comp6_comparator: cover property (src_is_comp1 ##1 deadtime_comp6_o);
	c_refclk_on_pin127: cover property (pin127_output_code == CODE_REF_CLK ##1 pin127_remapped_o);

endmodule // remappable_pin_select_matrix

// ---- pin_select_pkg.sv ----
package pin_select_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map and fields
	localparam int REG_W = 16;
	localparam int ADDR_W = 4;
	localparam int CODE_W = 6;
	localparam int SRC_W = 7;
	localparam int PIN_IN_N = 128;
	localparam logic [ADDR_W-1:0] ADDR_DTCOMP6_SEL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_PIN126_127_SEL = 4'h2;
	localparam int PIN126_LSB = 0;
	localparam int PIN127_LSB = 8;
	localparam int DTCOMP6_LSB = 0;
	localparam logic [REG_W-1:0] RST_SELECT = 16'h0000;
	localparam logic [CODE_W-1:0] RST_CODE = 6'h00;
	localparam logic [SRC_W-1:0] RST_SRC = 7'h00;

	////////////////////////////////////////////////////////////////////////
	// output function codes
	localparam logic [CODE_W-1:0] CODE_DEFAULT_PORT = 6'h00;
	localparam logic [CODE_W-1:0] CODE_SER1_TX = 6'h01;
	localparam logic [CODE_W-1:0] CODE_SER2_TX = 6'h03;
	localparam logic [CODE_W-1:0] CODE_SYNC2_DATA = 6'h08;
	localparam logic [CODE_W-1:0] CODE_SYNC2_CLK = 6'h09;
	localparam logic [CODE_W-1:0] CODE_SYNC2_SEL = 6'h0a;
	localparam logic [CODE_W-1:0] CODE_CODEC_DATA = 6'h0b;
	localparam logic [CODE_W-1:0] CODE_CODEC_CLK = 6'h0c;
	localparam logic [CODE_W-1:0] CODE_CODEC_FS = 6'h0d;
	localparam logic [CODE_W-1:0] CODE_CAN1_TX = 6'h0e;
	localparam logic [CODE_W-1:0] CODE_CAN2_TX = 6'h0f;
	localparam logic [CODE_W-1:0] CODE_COMPARE_FIRST = 6'h10;
	localparam logic [CODE_W-1:0] CODE_COMPARE_LAST = 6'h17;
	localparam logic [CODE_W-1:0] CODE_COMP1 = 6'h18;
	localparam logic [CODE_W-1:0] CODE_COMP2 = 6'h19;
	localparam logic [CODE_W-1:0] CODE_COMP3 = 6'h1a;
	localparam logic [CODE_W-1:0] CODE_SER3_TX = 6'h1b;
	localparam logic [CODE_W-1:0] CODE_SER3_RTS = 6'h1c;
	localparam logic [CODE_W-1:0] CODE_SER4_TX = 6'h1d;
	localparam logic [CODE_W-1:0] CODE_SER4_RTS = 6'h1e;
	localparam logic [CODE_W-1:0] CODE_SYNC3_DATA = 6'h1f;
	localparam logic [CODE_W-1:0] CODE_SYNC3_CLK = 6'h20;
	localparam logic [CODE_W-1:0] CODE_SYNC3_SEL = 6'h21;
	localparam logic [CODE_W-1:0] CODE_TB1_SYNC = 6'h2d;
	localparam logic [CODE_W-1:0] CODE_TB2_SYNC = 6'h2e;
	localparam logic [CODE_W-1:0] CODE_ENC1_CMP = 6'h2f;
	localparam logic [CODE_W-1:0] CODE_ENC2_CMP = 6'h30;
	localparam logic [CODE_W-1:0] CODE_REF_CLK = 6'h31;
	localparam logic [CODE_W-1:0] CODE_COMP4 = 6'h32;
	localparam logic [CODE_W-1:0] CODE_COMP5 = 6'h33;

	////////////////////////////////////////////////////////////////////////
	// peripheral output bundle: slot 0 idle, then in code order
	localparam int PERIPH_N = 36;
	localparam logic [5:0] SLOT_NONE = 6'h00;
	localparam logic [5:0] SLOT_SER1_TX = 6'h01;
	localparam logic [5:0] SLOT_SER2_TX = 6'h02;
	localparam logic [5:0] SLOT_SYNC2_BASE = 6'h03;
	localparam logic [5:0] SLOT_CODEC_BASE = 6'h06;
	localparam logic [5:0] SLOT_CAN_BASE = 6'h09;
	localparam logic [5:0] SLOT_COMPARE_BASE = 6'h0b;
	localparam logic [5:0] SLOT_COMP_LOW_BASE = 6'h13;
	localparam logic [5:0] SLOT_SER3_TX = 6'h16;
	localparam logic [5:0] SLOT_SER3_RTS = 6'h17;
	localparam logic [5:0] SLOT_SER4_TX = 6'h18;
	localparam logic [5:0] SLOT_SER4_RTS = 6'h19;
	localparam logic [5:0] SLOT_SYNC3_BASE = 6'h1a;
	localparam logic [5:0] SLOT_TB_BASE = 6'h1d;
	localparam logic [5:0] SLOT_ENC_BASE = 6'h1f;
	localparam logic [5:0] SLOT_REF_CLK = 6'h21;
	localparam logic [5:0] SLOT_COMP_HIGH_BASE = 6'h22;

	////////////////////////////////////////////////////////////////////////
	// dead-time compensation 6 source codes
	localparam logic [SRC_W-1:0] SRC_GROUND = 7'h00;
	localparam logic [SRC_W-1:0] SRC_COMP1 = 7'h01;
	localparam logic [SRC_W-1:0] SRC_PIN_MAX = 7'h7c;

endpackage

// ---- pin_route_if.sv ----
`timescale 1ns/1ps
interface pin_route_if;
	import pin_select_pkg::*;
	logic [CODE_W-1:0] code;
	logic [PERIPH_N-1:0] periph;
	logic routed;
	logic level;
	modport mux (input code, input periph, output routed, output level);
	modport ctrl (output code, output periph, input routed, input level);
endinterface

// ---- pin_output_mux.sv ----
`timescale 1ns/1ps
module pin_output_mux
	import pin_select_pkg::*;
(
	pin_route_if.mux rt
);

	// bundle slot for a code; slot none means no peripheral drives the pin
	function automatic logic [5:0] slot_of(input logic [CODE_W-1:0] code);
		logic [5:0] s;
		s = SLOT_NONE;
		unique case (code)
			CODE_SER1_TX: s = SLOT_SER1_TX;
			CODE_SER2_TX: s = SLOT_SER2_TX;
			CODE_SER3_TX: s = SLOT_SER3_TX;
			CODE_SER4_TX: s = SLOT_SER4_TX;
			CODE_SYNC2_DATA, CODE_SYNC2_CLK, CODE_SYNC2_SEL:
				s = SLOT_SYNC2_BASE + 6'(code - CODE_SYNC2_DATA);
			CODE_SYNC3_DATA, CODE_SYNC3_CLK, CODE_SYNC3_SEL:
				s = SLOT_SYNC3_BASE + 6'(code - CODE_SYNC3_DATA);
			CODE_CODEC_DATA, CODE_CODEC_CLK, CODE_CODEC_FS:
				s = SLOT_CODEC_BASE + 6'(code - CODE_CODEC_DATA);
			CODE_CAN1_TX, CODE_CAN2_TX:
				s = SLOT_CAN_BASE + 6'(code - CODE_CAN1_TX);
			CODE_COMP1, CODE_COMP2, CODE_COMP3:
				s = SLOT_COMP_LOW_BASE + 6'(code - CODE_COMP1);
			CODE_COMP4, CODE_COMP5:
				s = SLOT_COMP_HIGH_BASE + 6'(code - CODE_COMP4);
			CODE_SER3_RTS: s = SLOT_SER3_RTS;
			CODE_SER4_RTS: s = SLOT_SER4_RTS;
			CODE_TB1_SYNC, CODE_TB2_SYNC:
				s = SLOT_TB_BASE + 6'(code - CODE_TB1_SYNC);
			CODE_ENC1_CMP, CODE_ENC2_CMP:
				s = SLOT_ENC_BASE + 6'(code - CODE_ENC1_CMP);
			CODE_REF_CLK: s = SLOT_REF_CLK;
			default:
			begin
				if (code >= CODE_COMPARE_FIRST && code <= CODE_COMPARE_LAST)
				begin
					s = SLOT_COMPARE_BASE + 6'(code - CODE_COMPARE_FIRST);
				end
				else
				begin
					s = SLOT_NONE;
				end
			end
		endcase
		return s;
	endfunction

	logic [5:0] slot;

	assign slot = slot_of(rt.code);
	assign rt.routed = (slot != SLOT_NONE);
	assign rt.level = rt.periph[slot];

endmodule // pin_output_mux

// ---- periph_source_model.sv ----
`timescale 1ns/1ps
module periph_source_model
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	output logic [63:0] level_o
);
	////////////////////////////////////////////////////////////////////////
	// peripheral and port levels, bit c feeds the line selected by code c
	// xorshift scramble: lines change pseudo-randomly each cycle, so a wrong select or a lost cycle is unlikely to match by luck for long
	logic [63:0] next_level;
	logic [63:0] mix_a;
	logic [63:0] mix_b;
	assign mix_a = level_o ^ (level_o << 13);
	assign mix_b = mix_a ^ (mix_a >> 7);
	assign next_level = mix_b ^ (mix_b << 17);
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			level_o <= 64'h5a3c_96e1_0f87_d2b4;
		else
			level_o <= next_level;
	end
endmodule // periph_source_model

// ---- tb_remappable_pin_select_matrix.sv ----
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module tb_remappable_pin_select_matrix;
	import pin_select_pkg::*;
	logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
	logic [3:0] reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic [63:0] lv;
	logic [127:0] pins, pin_d1, pin_d2;
	logic [15:0] rd_o [2];
	logic [15:0] e_rd [2];
	logic [1:0] e126 [2];
	logic [1:0] e127 [2];
	logic p126 [2], p127 [2], r126 [2], r127 [2], dt [2];
	logic [5:0] m126, m127;
	logic [6:0] msrc;
	logic [1:0] live;
	logic e_dt;
	int num_errors = 0;
	int checks = 0;
	int unsigned seed;
	logic [15:0] w;
	logic [6:0] src_tab [6] = '{7'h00, 7'h01, 7'h02, 7'h7c, 7'h7d, 7'h7f};

	////////////////////////////////////////////////////////////////////////
	periph_source_model i_periph_source_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .level_o(lv));
	for (genvar v = 0; v < 2; v++)
	begin : g_var
		remappable_pin_select_matrix #(.LARGE_VARIANT(v == 0)) i_remappable_pin_select_matrix (
			.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
			.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rd_o[v]),
			.serial1_transmit_i(lv[1]), .serial2_transmit_i(lv[3]), .serial3_transmit_i(lv[27]),
			.serial4_transmit_i(lv[29]), .serial3_request_to_send_i(lv[28]), .serial4_request_to_send_i(lv[30]),
			.sync_port2_data_out_i(lv[8]), .sync_port2_clock_out_i(lv[9]), .sync_port2_select_out_i(lv[10]),
			.sync_port3_data_out_i(lv[31]), .sync_port3_clock_out_i(lv[32]), .sync_port3_select_out_i(lv[33]),
			.codec_data_out_i(lv[11]), .codec_clock_out_i(lv[12]), .codec_frame_sync_i(lv[13]),
			.can_unit1_transmit_i(lv[14]), .can_unit2_transmit_i(lv[15]), .compare_channel_out_i(lv[23:16]),
			.comparator_out_i({lv[51:50], lv[26:24]}), .primary_timebase_sync_out_i(lv[45]),
			.secondary_timebase_sync_out_i(lv[46]), .encoder1_counter_compare_out_i(lv[47]),
			.encoder2_counter_compare_out_i(lv[48]), .reference_clock_out_i(lv[49]),
			.port126_data_i(lv[0]), .port127_data_i(lv[2]), .comparator1_source_i(lv[5]),
			.remappable_input_pin_i(pins), .pin126_o(p126[v]), .pin127_o(p127[v]),
			.pin126_remapped_o(r126[v]), .pin127_remapped_o(r127[v]), .deadtime_comp6_o(dt[v]));
	end

	////////////////////////////////////////////////////////////////////////
	// behavioural model
	function automatic logic [1:0] pin_exp(input logic [5:0] c, input logic [63:0] l, input logic port);
		logic hit;
		hit = (c == 6'h01) || (c == 6'h03) || (c >= 6'h08 && c <= 6'h21) || (c >= 6'h2d && c <= 6'h33);
		return hit ? {1'b1, l[c]} : {1'b0, port};
	endfunction
	function automatic logic dt_exp(input logic [6:0] s, input logic [127:0] p, input logic cmp);
		if (s == 7'h01)
			return cmp;
		return (s == 7'h00 || s > 7'h7c) ? 1'b0 : p[s];
	endfunction
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{m126, m127, msrc, live, pin_d1, pin_d2} <= '0;
		end
		else
		begin
			live <= (live == 2'd3) ? live : live + 2'd1;
			pin_d1 <= pins;
			pin_d2 <= pin_d1;
			if (reg_wr_i && reg_addr_i == 4'h0)
				msrc <= reg_wdata_i[6:0];
			if (reg_wr_i && reg_addr_i == 4'h2)
				{m127, m126} <= {reg_wdata_i[13:8], reg_wdata_i[5:0]};
			e_rd[0] <= !reg_rd_i ? 16'h0 : reg_addr_i == 4'h0 ? {9'h0, msrc} :
				reg_addr_i == 4'h2 ? {2'h0, m127, 2'h0, m126} : 16'h0;
			e_rd[1] <= (reg_rd_i && reg_addr_i == 4'h0) ? {9'h0, msrc} : 16'h0;
			e126[0] <= pin_exp(m126, lv, lv[0]);
			e127[0] <= pin_exp(m127, lv, lv[2]);
			e126[1] <= {1'b0, lv[0]};
			e127[1] <= {1'b0, lv[2]};
			e_dt <= dt_exp(msrc, pin_d2, lv[5]);
		end
	end
	// first edges after release are skipped: the expected values are not reset and start out stale
	always @(negedge sys_clk_i)
	begin
		for (int v = 0; v < 2; v++)
		begin
			if (!rst_n_i)
				`CHK({rd_o[v], r126[v], p126[v], r127[v], p127[v], dt[v]}, 21'h0, "reset outputs")
			else if (live == 2'd3)
			begin
				`CHK(rd_o[v], e_rd[v], "read data")
				`CHK({r126[v], p126[v]}, e126[v], "pin 126")
				`CHK({r127[v], p127[v]}, e127[v], "pin 127")
				`CHK(dt[v], e_dt, "deadtime input")
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic bus(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d);
		pins <= {$urandom, $urandom, $urandom, $urandom};
		reg_wr_i <= wr;
		reg_rd_i <= rd;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
	endtask
	task automatic done(input string name);
		$display("test %s done, errors %0d", name, num_errors);
	endtask
	task automatic finish_test();
		$display("checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#40000;
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test();
	end
	initial
	begin
		{rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pins} = '0;
		seed = $urandom(64374);
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) bus(0, 0, 4'h0, 16'h0);
		bus(0, 1, 4'h0, 16'h0);
		bus(0, 1, 4'h2, 16'h0);
		done("reset values");
		// every output code on pin 126, its mirror on pin 127; unimplemented bits get random junk
		for (int c = 0; c < 64; c++)
		begin
			w = 16'($urandom);
			w[13:8] = 6'(63 - c);
			w[5:0] = 6'(c);
			bus(1, 0, 4'h2, w);
			bus(0, 1, 4'h2, 16'h0);
			repeat (3) bus(0, 0, 4'h0, 16'h0);
		end
		done("output codes");
		for (int i = 0; i < 14; i++)
		begin
			w = 16'($urandom);
			if (i < 6)
				w[6:0] = src_tab[i];
			bus(1, 0, 4'h0, w);
			repeat (5) bus(0, 0, 4'h0, 16'h0);
			bus(0, 1, 4'h0, 16'h0);
		end
		done("deadtime source");
		for (int a = 1; a < 16; a++)
		begin
			if (a != 2)
			begin
				bus(1, 0, 4'(a), 16'($urandom));
				bus(0, 1, 4'(a), 16'h0);
			end
		end
		bus(0, 1, 4'h0, 16'h0);
		bus(0, 1, 4'h2, 16'h0);
		done("unmapped addresses");
		bus(1, 0, 4'h2, 16'h2d31);
		bus(0, 0, 4'h0, 16'h0);
		rst_n_i <= 1'b0;
		repeat (2) bus(0, 0, 4'h0, 16'h0);
		rst_n_i <= 1'b1;
		repeat (3) bus(0, 0, 4'h0, 16'h0);
		bus(0, 1, 4'h2, 16'h0);
		bus(0, 1, 4'h0, 16'h0);
		repeat (2) bus(0, 0, 4'h0, 16'h0);
		done("mid-run reset");
		finish_test();
	end
endmodule // tb_remappable_pin_select_matrix
